// ---- dv/gpio_pin_world.sv ----
/* outside world of the pins: resolves every pin from the block's
   drivers and the bench's drivers; undriven pins wander. */
`default_nettype none
module gpio_pin_world
(
  // clock
  input  wire logic [0:0] ref_clk,
  // block pin drivers
  input  wire logic [4:0] g_pin_out,
  input  wire logic [4:0] g_pin_oe,
  input  wire logic [7:0] h_pin_out,
  input  wire logic [7:0] h_pin_oe,
  // outside drivers set by the bench
  input  wire logic [4:0] g_ext,
  input  wire logic [4:0] g_ext_en,
  input  wire logic [7:0] h_ext,
  input  wire logic [7:0] h_ext_en,
  // resolved levels
  output logic      [4:0] g_pin_in,
  output logic      [7:0] h_pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] wander = 8'h55; // floating level, flips every cycle
  always @(posedge ref_clk) begin
    wander <= ~wander;
  end
  // block driver wins, then outside driver, else floating
  assign g_pin_in = (g_pin_oe & g_pin_out) | (~g_pin_oe & ((g_ext_en & g_ext)
                    | (~g_ext_en & wander[4:0])));
  assign h_pin_in = (h_pin_oe & h_pin_out) | (~h_pin_oe & ((h_ext_en & h_ext)
                    | (~h_ext_en & wander)));
endmodule // gpio_pin_world
`default_nettype wire

// ---- dv/gpio_ports_g_h_props.sv ----
/* pin and bus relations of the port g / port h gpio block.
   assumes ce held high and a single ref_clk domain. */
`default_nettype none
module gpio_ports_g_h_props
  import gpio_gh_pkg::*;
(
  // clock and resets
  input wire logic          ref_clk,
  input wire logic          rst_n,
  input wire logic          soft_rst_n,
  // bus handshakes
  input wire logic          awvalid,
  input wire logic          awready,
  input wire logic          wvalid,
  input wire logic          wready,
  input wire logic          bvalid,
  input wire logic          arvalid,
  input wire logic          arready,
  input wire logic          rvalid,
  input wire logic [31:0]   rdata,
  // pins and peripherals
  input wire logic [4:0]    g_pin_in,
  input wire logic [4:0]    g_pin_out,
  input wire logic [4:0]    g_pin_oe,
  input wire logic [7:0]    h_pin_out,
  input wire logic [7:0]    h_pin_oe,
  input wire periph_claim_t g_claim,
  input wire logic [4:0]    g_level,
  input wire logic [3:0]    ext_address_high_bits,
  input wire logic          ext_bus_active
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n || !soft_rst_n);
  // pins a peripheral forces to output or to input
  wire [4:0] drv = g_claim.own & g_claim.force_out;
  wire [4:0] inp = g_claim.own & ~g_claim.force_out;

  a_claim_drive: assert property (drv != 5'h00 |=>
    (g_pin_oe & $past(drv)) == $past(drv)
    && ((g_pin_out ^ $past(g_claim.data)) & $past(drv)) == 5'h00)
    else $error("claimed output pin not driven with claim data");
  a_claim_input: assert property (inp != 5'h00 |=>
    (g_pin_oe & $past(inp)) == 5'h00)
    else $error("pin forced to input still driven");
  a_bus_addr: assert property (ext_bus_active |=>
    h_pin_oe[3:0] == 4'hF
    && h_pin_out[3:0] == $past(ext_address_high_bits))
    else $error("address bits not on port h low pins");
  a_write_resp: assert property (
    awvalid && awready && wvalid && wready |-> ##2 bvalid)
    else $error("write response late");
  a_read_resp: assert property (arvalid && arready |=> rvalid)
    else $error("read data late");
  a_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_reset_inputs: assert property (disable iff (1'b0)
    !rst_n |=> g_pin_oe == 5'h00)
    else $error("port g driven after power-on reset");
  a_level_sync: assert property (
    $changed(g_pin_in) ##1 $stable(g_pin_in) [*5] |-> g_level == g_pin_in)
    else $error("pin level not passed through");
endmodule // gpio_ports_g_h_props

bind gpio_ports_g_h gpio_ports_g_h_props gpio_ports_g_h_props_i (.*);
`default_nettype wire

// ---- dv/test_gpio_ports_g_h.sv ----
/* register and pin tests of the port g / port h gpio block.
   assumes the pin model closes the pins and ce stays high. */
`default_nettype none
module test_gpio_ports_g_h import gpio_gh_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic          ref_clk = 1'b0;
  logic          rst_n, soft_rst_n, ce;
  logic [4:0]    awaddr, araddr;
  logic [31:0]   wdata, rdata, seen;
  logic [3:0]    wstrb, ext_address_high_bits;
  logic [1:0]    bresp, rresp, seen_resp;
  logic          awvalid, awready, wvalid, wready, bvalid, bready;
  logic          arvalid, arready, rvalid, rready, ext_bus_active;
  logic [4:0]    g_pin_in, g_pin_out, g_pin_oe, g_level, g_ext, g_ext_en;
  logic [7:0]    h_pin_in, h_pin_out, h_pin_oe, h_ext, h_ext_en;
  periph_claim_t g_claim;
  int            fail_count = 0;
  int            total_checks = 0;

  always #10 ref_clk = ~ref_clk; // 50 mhz
  gpio_ports_g_h gpio_ports_g_h_i (.*);
  gpio_pin_world gpio_pin_world_i (.*);

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one write; address and data offered together
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge ref_clk);
    {awaddr, wdata} <= {a, 24'h0, d};
    {awvalid, wvalid, bready} <= 3'h7;
    while (n < 40) begin
      @(posedge ref_clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) begin
        bready <= 1'b0;
        check(32'(bresp), 32'(RESP_OKAY));
        n = 99;
      end
    end
    if (n == 40) fail_count++;
  endtask
  // one read into seen and seen_resp
  task automatic rd(input logic [4:0] a);
    int n;
    n = 0;
    @(posedge ref_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    do begin
      @(posedge ref_clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    {seen, seen_resp} = {rdata, rresp};
    rready <= 1'b0;
    if (n == 40) fail_count++;
  endtask
  task automatic rc(input logic [4:0] a, input logic [31:0] exp);
    rd(a);
    check(seen, exp);
    check(32'(seen_resp), 32'(RESP_OKAY));
  endtask

  initial begin
    {rst_n, soft_rst_n, ce, wstrb} = 7'h31;
    {awaddr, araddr, wdata, awvalid, wvalid, bready} = '0;
    {arvalid, rready, g_claim} = '0;
    {g_ext, g_ext_en, h_ext, h_ext_en} = 26'h001F_F0F0;
    ext_address_high_bits = 4'hA;
    repeat (3) @(posedge ref_clk);
    rst_n <= 1'b1;
    // reset values, analog and bus defaults
    rc(OFS_G_DIR, 32'(G_DIR_RST));
    rc(OFS_H_DIR, 32'(H_DIR_RST));
    rc(OFS_ANALOG, 32'(ANALOG_RST));
    rc(OFS_MEMORY_INTERFACE_CONTROL, 32'(MEMORY_INTERFACE_CONTROL_RST));
    rc(OFS_H_PIN, 32'h0A);
    check(32'(h_pin_oe), 32'h0F);
    $display("test reset values done");
    // port g latch, direction and pin read
    wr(OFS_G_LATCH, 8'hFF);
    rc(OFS_G_LATCH, 32'h1F);
    g_ext_en <= 5'h00;
    wr(OFS_G_DIR, 8'h00);
    wr(OFS_G_PIN, 8'h0A);
    @(negedge ref_clk);
    check(32'(g_pin_oe), 32'h1F);
    check(32'(g_pin_out), 32'h0A);
    wr(OFS_G_DIR, 8'h1F);
    {g_ext, g_ext_en} <= 10'h2BF;
    repeat (6) @(negedge ref_clk);
    check(32'(g_pin_oe), 32'h0);
    rc(OFS_G_PIN, 32'h15);
    check(32'(g_level), 32'h15);
    rc(OFS_G_LATCH, 32'h0A);
    $display("test port g done");
    // peripheral overrides leave the direction register alone
    g_ext_en <= 5'h00;
    g_claim <= '{5'h03, 5'h01, 5'h01};
    repeat (2) @(negedge ref_clk);
    check(32'(g_pin_oe), 32'h01);
    check(32'(g_pin_out[PIN_CAPTURE_COMPARE_PWM_CH3]), 32'h1);
    rc(OFS_G_DIR, 32'h1F);
    wr(OFS_G_DIR, 8'h00);
    @(negedge ref_clk);
    check(32'(g_pin_oe[PIN_SER2_TX]), 32'h0);
    rc(OFS_G_DIR, 32'h00);
    $display("test overrides done");
    // port h as plain i/o, then analog selection
    g_claim <= '0;
    wr(OFS_MEMORY_INTERFACE_CONTROL, 8'hFF);
    rc(OFS_MEMORY_INTERFACE_CONTROL, 32'(MEMORY_INTERFACE_CONTROL_MASK));
    check(32'(ext_bus_active), 32'h0);
    h_ext_en <= 8'h00;
    wr(OFS_H_LATCH, 8'h5C);
    wr(OFS_H_DIR, 8'h00);
    @(negedge ref_clk);
    check(32'(h_pin_oe), 32'hFF);
    check(32'(h_pin_out), 32'h5C);
    wr(OFS_H_DIR, 8'hFF);
    {h_ext, h_ext_en} <= 16'hA5FF;
    wr(OFS_ANALOG, 8'h04);
    rc(OFS_H_PIN, 32'hA5);
    wr(OFS_ANALOG, 8'h02);
    rc(OFS_H_PIN, 32'h85);
    $display("test port h done");
    // other resets keep latches, restore direction
    soft_rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    soft_rst_n <= 1'b1;
    rc(OFS_G_LATCH, 32'h0A);
    rc(OFS_H_LATCH, 32'h5C);
    rc(OFS_G_DIR, 32'(G_DIR_RST));
    rd(5'h02);
    check(seen, 32'h0);
    check(32'(seen_resp), 32'(RESP_SLVERR));
    check(32'(ext_bus_active), 32'h1);
    $display("test soft reset done");
    end_sim();
  end
  // the tests need well under a thousand cycles
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
endmodule // test_gpio_ports_g_h
`default_nettype wire

// ---- rtl/gpio_gh_pkg.sv ----
/*
  constants, register map and carrier types for the port g / port h
  general purpose i/o block.
  assumes a single 50 mhz clock and an axi4-lite master with 32-bit data.
*/
// Contract
// (RULE1) direction one: pin input, driver off
// (RULE2) direction zero: drive pin from latch
// (RULE3) latch register readable, returns latch value
// (RULE4) port g five pins, bits 4..0
// (RULE5) port h eight pins, full bit set
// (RULE6) owning peripheral forces pin direction
// (RULE7) override never stored in direction register
// (RULE8) power-on: port g direction all ones
// (RULE9) port g pins mapped to ccp, serial2
// (RULE10) port h 7..4 analog or digital select
// (RULE11) port h 3..0 carry high address bits
// (RULE12) analog port h pins read zero
// (RULE13) port h 3..0 default to address bus
// (RULE14) port h latch kept across other resets
// (RULE15) port g latch drives outputs, kept
// (RULE16) port read gives pins, write sets latch
// (RULE17) port g bits 7..5 read zero
`default_nettype none
package gpio_gh_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_G_PIN    = 5'h00;
  localparam logic [4:0] OFS_G_LATCH  = 5'h04;
  localparam logic [4:0] OFS_G_DIR    = 5'h08;
  localparam logic [4:0] OFS_H_PIN    = 5'h0C;
  localparam logic [4:0] OFS_H_LATCH  = 5'h10;
  localparam logic [4:0] OFS_H_DIR    = 5'h14;
  localparam logic [4:0] OFS_ANALOG   = 5'h18;
  localparam logic [4:0] OFS_MEMORY_INTERFACE_CONTROL   = 5'h1C;
  // widths
  localparam int G_W = 5;
  localparam int H_W = 8;
  // reset values
  localparam logic [4:0] G_DIR_RST    = 5'h1F;
  localparam logic [7:0] H_DIR_RST    = 8'hFF;
  localparam logic [7:0] ANALOG_RST   = 8'h00;
  localparam logic [7:0] MEMORY_INTERFACE_CONTROL_RST   = 8'h00;
  localparam logic [4:0] G_LATCH_RST  = 5'h00;
  localparam logic [7:0] H_LATCH_RST  = 8'h00;
  // writable bit masks of the config registers
  localparam logic [7:0] ANALOG_MASK  = 8'h3F;
  localparam logic [7:0] MEMORY_INTERFACE_CONTROL_MASK  = 8'hB3;
  // field positions
  localparam int EXT_BUS_DIS_BIT = 7;
  localparam int PORT_CFG_LSB    = 0;
  localparam int PORT_CFG_W      = 4;
  // port g pin roles
  localparam int PIN_CAPTURE_COMPARE_PWM_CH3    = 0;
  localparam int PIN_SER2_TX = 1;
  localparam int PIN_SER2_RX = 2;
  localparam int PIN_CAPTURE_COMPARE_PWM_CH4    = 3;
  localparam int PIN_CAPTURE_COMPARE_PWM_CH5    = 4;
  // first analog channel on port h bit 4
  localparam int ANALOG_BASE_CH = 12;
  localparam int ANALOG_CH_TOP  = 16;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // pins of one port: value out, output enable
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } pin_drive_t;

  // peripheral claims on port g pins
  typedef struct packed {
    logic [4:0] own;       // peripheral enabled and owns pin
    logic [4:0] force_out; // 1 forces output, 0 forces input
    logic [4:0] data;      // value driven when forced output
  } periph_claim_t;
endpackage
`default_nettype wire

// ---- rtl/gpio_ports_g_h.sv ----
/*
  port g (5 pins) and port h (8 pins) general purpose i/o with an
  axi4-lite register slave, peripheral direction overrides, analog
  pin selection and external address bus sharing.
  assumes pins arrive asynchronously and are resolved by the bench from
  out/oe; peripherals and the address source share ref_clk.
*/
// Our own choices: the address map and register access over AXI4-Lite.
`default_nettype none
module gpio_ports_g_h
  import gpio_gh_pkg::*;
(
  // clock, resets, enable
  input  wire logic        ref_clk,
  input  wire logic        rst_n,       // power-on / brown-out reset
  input  wire logic        soft_rst_n,  // every other reset
  input  wire logic        ce,
  // axi4-lite write address
  input  wire logic [4:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  // axi4-lite write data
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read address
  input  wire logic [4:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  // axi4-lite read data
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // port g pins
  input  wire logic [4:0]  g_pin_in,
  output logic [4:0]       g_pin_out,
  output logic [4:0]       g_pin_oe,
  // port h pins
  input  wire logic [7:0]  h_pin_in,
  output logic [7:0]       h_pin_out,
  output logic [7:0]       h_pin_oe,
  // peripherals on port g
  input  wire periph_claim_t g_claim,
  output logic [4:0]       g_level,     // filtered pin level to them
  // external memory interface
  input  wire logic [3:0]  ext_address_high_bits,
  output logic             ext_bus_active
);

  // software registers
  logic [4:0] g_latch;     // port g output latch
  logic [4:0] g_dir;       // port g direction, 1 = input
  logic [7:0] h_latch;     // port h output latch
  logic [7:0] h_dir;       // port h direction, 1 = input
  logic [7:0] analog_pin_config;
  logic [7:0] memory_interface_control;

  // pin synchronisers and filtered levels
  logic [4:0] g_s1, g_s2, g_s3;
  logic [7:0] h_s1, h_s2, h_s3;
  logic [4:0] g_stable;    // accepted port g level
  logic [7:0] h_stable;    // accepted port h level

  // bus slave state
  logic        aw_held;    // write address captured
  logic        w_held;     // write data captured
  logic [4:0]  aw_addr;    // captured write address
  logic [7:0]  w_byte;     // captured low data byte
  logic        w_lane;     // captured wstrb[0]

  // pin function selection
  wire       bus_mode = ~memory_interface_control[EXT_BUS_DIS_BIT];
  wire [3:0] port_cfg =
    analog_pin_config[PORT_CFG_LSB +: PORT_CFG_W];
  logic [3:0] h_analog;    // per upper port h pin, 1 = analog

  // channel n is analog while the config field is below 16 - n
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_analog
      localparam logic [4:0] LIMIT =
        5'(ANALOG_CH_TOP - ANALOG_BASE_CH - gi);
      assign h_analog[gi] = ({1'b0, port_cfg} < LIMIT); // RULE10
    end
  endgenerate

  // ---------------------------------------------------------------
  // port g drive: peripheral claim overrides the stored direction
  // ---------------------------------------------------------------
  wire [4:0] g_force_out = g_claim.own & g_claim.force_out; // RULE6
  wire [4:0] g_oe_next =
    (g_claim.own & g_claim.force_out) |
    (~g_claim.own & ~g_dir);                           // RULE1 RULE2
  wire [4:0] g_out_next =
    (g_force_out & g_claim.data) |
    (~g_force_out & g_latch);                           // RULE15 RULE9

  // ---------------------------------------------------------------
  // port h drive: low nibble carries address bits in bus mode
  // ---------------------------------------------------------------
  wire [7:0] h_oe_next = {~h_dir[7:4],
    bus_mode ? 4'hF : ~h_dir[3:0]};                    // RULE11 RULE1
  wire [7:0] h_out_next = {h_latch[7:4],
    bus_mode ? ext_address_high_bits : h_latch[3:0]};  // RULE11 RULE2

  // ---------------------------------------------------------------
  // write decode
  // ---------------------------------------------------------------
  wire do_write = aw_held & w_held & ~bvalid;
  wire wr_en    = do_write & w_lane;
  wire wr_g_port  = wr_en & (aw_addr == OFS_G_PIN);
  wire wr_g_latch = wr_en & (aw_addr == OFS_G_LATCH);
  wire wr_g_dir   = wr_en & (aw_addr == OFS_G_DIR);
  wire wr_h_port  = wr_en & (aw_addr == OFS_H_PIN);
  wire wr_h_latch = wr_en & (aw_addr == OFS_H_LATCH);
  wire wr_h_dir   = wr_en & (aw_addr == OFS_H_DIR);
  wire wr_analog  = wr_en & (aw_addr == OFS_ANALOG);
  wire wr_memory_interface_control  = wr_en & (aw_addr == OFS_MEMORY_INTERFACE_CONTROL);
  wire wr_hit = (aw_addr == OFS_G_PIN)   | (aw_addr == OFS_G_LATCH) |
                (aw_addr == OFS_G_DIR)   | (aw_addr == OFS_H_PIN)   |
                (aw_addr == OFS_H_LATCH) | (aw_addr == OFS_H_DIR)   |
                (aw_addr == OFS_ANALOG)  | (aw_addr == OFS_MEMORY_INTERFACE_CONTROL);

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  wire [7:0] g_pin_view = {3'h0, g_stable};              // RULE17 RULE16
  wire [7:0] h_pin_view =
    {h_stable[7:4] & ~h_analog, h_stable[3:0]};          // RULE12 RULE16
  logic [7:0] rd_byte;     // selected register value
  logic       rd_hit;      // address maps to a register

  // combinational read mux, narrow registers padded with zero
  always_comb begin
    rd_hit  = 1'b1;
    case (araddr)
      OFS_G_PIN:   rd_byte = g_pin_view;
      OFS_G_LATCH: rd_byte = {3'h0, g_latch};            // RULE3 RULE17
      OFS_G_DIR:   rd_byte = {3'h0, g_dir};              // RULE7 RULE4
      OFS_H_PIN:   rd_byte = h_pin_view;
      OFS_H_LATCH: rd_byte = h_latch;                    // RULE3 RULE5
      OFS_H_DIR:   rd_byte = h_dir;                      // RULE7
      OFS_ANALOG:  rd_byte = analog_pin_config;
      OFS_MEMORY_INTERFACE_CONTROL:  rd_byte = memory_interface_control;
      default: begin
        rd_byte = 8'h00;
        rd_hit  = 1'b0;
      end
    endcase
  end

  // handshake outputs, stalled while the clock enable is low
  assign awready = ce & ~aw_held;
  assign wready  = ce & ~w_held;
  assign arready = ce & ~rvalid;

  // status outputs
  assign g_level        = g_stable;
  assign ext_bus_active = bus_mode;

  // ---------------------------------------------------------------
  // pin synchronisers: three stages, a change is accepted once the
  // second and third stage agree
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      g_s1 <= 5'h00;
      g_s2 <= 5'h00;
      g_s3 <= 5'h00;
      h_s1 <= 8'h00;
      h_s2 <= 8'h00;
      h_s3 <= 8'h00;
    end else if (ce) begin
      g_s1 <= g_pin_in;
      g_s2 <= g_s1;
      g_s3 <= g_s2;
      h_s1 <= h_pin_in;
      h_s2 <= h_s1;
      h_s3 <= h_s2;
    end
  end

  // accepted levels update per bit where stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      g_stable <= 5'h00;
      h_stable <= 8'h00;
    end else if (ce) begin
      g_stable <= (g_s2 & ~(g_s2 ^ g_s3)) | (g_stable & (g_s2 ^ g_s3));
      h_stable <= (h_s2 & ~(h_s2 ^ h_s3)) | (h_stable & (h_s2 ^ h_s3));
    end
  end

  // ---------------------------------------------------------------
  // output latches: cleared only by power-on reset, kept otherwise
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      g_latch <= G_LATCH_RST;                            // RULE15
      h_latch <= H_LATCH_RST;                            // RULE14
    end else if (ce) begin
      if (wr_g_port || wr_g_latch) begin
        g_latch <= w_byte[4:0];                          // RULE16 RULE4
      end
      if (wr_h_port || wr_h_latch) begin
        h_latch <= w_byte;                               // RULE16 RULE5
      end
    end
  end

  // ---------------------------------------------------------------
  // direction and pin function registers, reset by every reset
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !soft_rst_n) begin
      g_dir                    <= G_DIR_RST;             // RULE8
      h_dir                    <= H_DIR_RST;
      analog_pin_config        <= ANALOG_RST;            // RULE12
      memory_interface_control <= MEMORY_INTERFACE_CONTROL_RST;            // RULE13
    end else if (ce) begin
      if (wr_g_dir) begin
        g_dir <= w_byte[4:0];                            // RULE7 RULE17
      end
      if (wr_h_dir) begin
        h_dir <= w_byte;
      end
      if (wr_analog) begin
        analog_pin_config <= w_byte & ANALOG_MASK;
      end
      if (wr_memory_interface_control) begin
        memory_interface_control <= w_byte & MEMORY_INTERFACE_CONTROL_MASK;
      end
    end
  end

  // ---------------------------------------------------------------
  // registered pin drive
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      g_pin_out <= 5'h00;
      g_pin_oe  <= 5'h00;
      h_pin_out <= 8'h00;
      h_pin_oe  <= 8'h00;
    end else if (ce) begin
      g_pin_out <= g_out_next;
      g_pin_oe  <= g_oe_next;
      h_pin_out <= h_out_next;
      h_pin_oe  <= h_oe_next;
    end
  end

  // ---------------------------------------------------------------
  // write channels: address and data taken in either order
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !soft_rst_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 5'h00;
      w_byte  <= 8'h00;
      w_lane  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else if (ce) begin
      // capture address
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end
      // capture data
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_byte <= wdata[7:0];
        w_lane <= wstrb[0];
      end
      // both present: commit and answer
      if (do_write) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        bresp   <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // read channel: one cycle from address to data
  // ---------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rst_n || !soft_rst_n) begin
      rvalid <= 1'b0;
      rdata  <= 32'h00000000;
      rresp  <= RESP_OKAY;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata  <= {24'h000000, rd_byte};
        rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

endmodule // gpio_ports_g_h
`default_nettype wire
